//--- sqp_pkg.sv
// constants and helpers shared by the servo quadrature/pwm io block
package sqp_pkg;
    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;       // 40 MHz core clock
    localparam int WD_TIME_NS    = 6500000;  // watchdog trip time
    localparam int WD_CYCLES     = WD_TIME_NS / CLK_PERIOD_NS;
    localparam int FILT_TIME_NS  = 175;      // shortest accepted pulse
    localparam int FILT_CYCLES   =
        (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWM_PERIOD    = 2047;     // carrier period in clocks
    // ==================================================================
    // sizes
    localparam int NCH     = 4;   // quadrature and pwm channels
    localparam int QCNT_W  = 14;  // counter width, wraps mod 2^14
    localparam int PWM_W   = 12;  // signed duty setting
    localparam int NDOUT   = 18;  // digital outputs
    localparam int NDED    = 10;  // dedicated digital outputs
    localparam int NDIN    = 20;  // digital inputs
    localparam int NDED_IN = 8;   // dedicated digital inputs
    localparam int ADR_W   = 8;
    // ==================================================================
    // register byte offsets
    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_DOUT  = 8'h04;
    localparam logic [7:0] ADR_INV   = 8'h08;
    localparam logic [7:0] ADR_DIN   = 8'h0C;
    localparam logic [7:0] ADR_QCNT0 = 8'h10;  // 0x10..0x1C
    localparam logic [7:0] ADR_PWM0  = 8'h20;  // 0x20..0x2C
    localparam logic [7:0] ADR_STAT  = 8'h30;
    // ==================================================================
    // field positions and reset values
    localparam int CTRL_DIR_LSB   = 0;   // pwm+direction selects
    localparam int CTRL_PDM_LSB   = 4;   // pulse-density selects
    localparam int CTRL_WDEN_BIT  = 8;   // watchdog enable
    localparam int CTRL_OUTEN_BIT = 9;   // drive the output pins
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
    localparam int PWM_UPO_BIT    = 16;  // shared output on up pin
    localparam int PWM_DNO_BIT    = 17;  // shared output on down pin
    localparam int QCNT_IDX_BIT   = 31;  // index seen since last read
    localparam int STAT_WD_BIT    = 0;   // watchdog has tripped

    // byte-lane merge of write data into the current value
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction
endpackage

//--- sqp_quad.sv
// one 4x quadrature counter with rising-edge index capture
`timescale 1ns/1ps
module sqp_quad
    import sqp_pkg::*;
#(
    parameter int CW = QCNT_W
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          phase_a,   // filtered a input
    input  wire logic          phase_b,   // filtered b input
    input  wire logic          index,     // filtered index input
    input  wire logic          idx_clr,   // host read of this counter
    output logic [CW-1:0]      count,
    output logic               idx_seen
);
    // ==================================================================
    // state
    logic          a_q, b_q, z_q;    // previous samples
    logic [CW-1:0] cnt_q, cnt_d;     // position
    logic          seen_q, seen_d;   // sticky index flag
    logic          rise;

    // next state: one count per edge of a or b
    always_comb begin
        cnt_d = cnt_q;
        // both phases moving at once is illegal; hold
        if ((a_q ^ phase_a) != (b_q ^ phase_b)) begin
            if (a_q ^ phase_b) begin
                cnt_d = cnt_q + 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
        rise   = index & ~z_q;
        // a new index beats the clear
        seen_d = rise | (seen_q & ~idx_clr);
    end

    // registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_q    <= 1'b0;
            b_q    <= 1'b0;
            z_q    <= 1'b0;
            cnt_q  <= '0;
            seen_q <= 1'b0;
        end else begin
            a_q    <= phase_a;
            b_q    <= phase_b;
            z_q    <= index;
            cnt_q  <= cnt_d;
            seen_q <= seen_d;
        end
    end

    assign count    = cnt_q;
    assign idx_seen = seen_q;

    // ==================================================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_count_step: assert property ((a_q ^ phase_a) && !(b_q ^ phase_b)
        |=> CW'(cnt_q - $past(cnt_q)) == CW'(1)
            || CW'($past(cnt_q) - cnt_q) == CW'(1))
        else $error("counter missed an a edge");
    a_index_rise: assert property ($rose(seen_q) |-> $past(index)
        && !$past(z_q))
        else $error("index flag set without rising edge");
    c_index: cover property ($rose(seen_q));
endmodule

//--- sqp_pwm.sv
// one signed pwm generator: up/down or pwm+direction, fixed or pdm
`timescale 1ns/1ps
module sqp_pwm
    import sqp_pkg::*;
#(
    parameter int W   = PWM_W,
    parameter int PER = PWM_PERIOD
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic [W-1:0]  value,     // two's complement duty
    input  wire logic          pwmdir,    // pwm+direction style
    input  wire logic          pdm,       // pulse-density style
    output logic               up_out,
    output logic               down_out
);
    localparam int MW = W - 1;
    localparam logic [MW-1:0] PLAST = MW'(PER - 1);
    // ==================================================================
    // state
    logic [MW-1:0] cnt_q, cnt_d;   // carrier position
    logic [MW-1:0] acc_q, acc_d;   // pdm accumulator
    logic          up_q, up_d, dn_q, dn_d;
    logic [MW-1:0] mag;
    logic [MW:0]   sum;
    logic          neg, pulse, carry;

    // magnitude of the setting; most negative code clamps to full
    always_comb begin
        neg = value[W-1];
        if (value == {1'b1, {MW{1'b0}}}) begin
            mag = {MW{1'b1}};
        end else if (neg) begin
            mag = MW'(-value);
        end else begin
            mag = value[MW-1:0];
        end
        // period of PER clocks, full magnitude never switches off
        cnt_d = (cnt_q == PLAST) ? '0 : cnt_q + 1'b1;
        // pdm: carry out of a modulo-PER accumulator
        sum   = {1'b0, acc_q} + {1'b0, mag};
        carry = sum >= (MW+1)'(PER);
        acc_d = carry ? MW'(sum - (MW+1)'(PER)) : sum[MW-1:0];
        pulse = pdm ? carry : (cnt_q < mag);
        if (pwmdir) begin
            up_d = pulse;
            dn_d = neg;
        end else begin
            up_d = pulse & ~neg;
            dn_d = pulse & neg;
        end
    end

    // registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            acc_q <= '0;
            up_q  <= 1'b0;
            dn_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            acc_q <= acc_d;
            up_q  <= up_d;
            dn_q  <= dn_d;
        end
    end

    assign up_out   = up_q;
    assign down_out = dn_q;

    // ==================================================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_dir_sign: assert property (pwmdir |=> dn_q == $past(value[W-1]))
        else $error("direction does not follow sign");
    a_period_wrap: assert property (cnt_q == PLAST |=> cnt_q == 0)
        else $error("carrier period wrong");
    a_zero_off: assert property (value == 0 && !pwmdir |=> !up_q && !dn_q)
        else $error("zero duty produced a pulse");
    c_full: cover property (mag == {MW{1'b1}} && up_q);
endmodule

//--- sqp_top.sv
// servo io top: wishbone registers, filters, counters, pwm, watchdog
// Function
// - watchdog tristates outputs after 6.5 ms idle
// - watchdog on at reset, pins tristated
// - direction high when command negative, invertible
// - index counts on rising edge only
// - sample every 25 ns, reject under 175 ns
// - status light is up0 xor down0
// - four quadrature channels sampled at 40 MHz
// - 4x counting, one step per edge
// - counter resolves 8191 counts between reads
// - 4095 signed duty levels including zero
// - carrier period is 2047 clocks
// - pwm+direction puts pulse on up pin
// - pwm+direction puts sign on down pin
// - pulse-density mode also offered
// - 18 outputs, 8 shared xored on pwm
// - 20 inputs, 12 shared with quadrature pins
// - invert flag makes shared pin active low
// - dedicated outputs update together, shared with pwm
// - all inputs latched at one instant
`timescale 1ns/1ps
module sqp_top
    import sqp_pkg::*;
#(
    parameter int WD_LIMIT = WD_CYCLES   // shorten for simulation
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_we_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [NDED_IN-1:0] digital_input_n,
    input  wire logic [NCH-1:0]    quad_phase_a_in,
    input  wire logic [NCH-1:0]    quad_phase_b_in,
    input  wire logic [NCH-1:0]    quad_index_in,
    output logic [NCH-1:0]         pwm_up_out,
    output logic [NCH-1:0]         pwm_up_oe,
    output logic [NCH-1:0]         pwm_down_out,
    output logic [NCH-1:0]         pwm_down_oe,
    output logic [NDED-1:0]        digital_output_n,
    output logic [NDED-1:0]        digital_output_oe,
    output logic                   led_out
);
    localparam int WDW = $clog2(WD_LIMIT + 1);
    localparam logic [WDW-1:0] WD_END = WDW'(WD_LIMIT);
    localparam logic [2:0] FLAST = 3'(FILT_CYCLES - 1);

    // ==================================================================
    // input filter: a level must stand FILT_CYCLES samples to pass
    logic [NDIN-1:0] raw, flt_q, flt_d;      // IN0..IN19 order
    logic [2:0]      fcnt_q [NDIN];          // disagreeing samples
    logic [2:0]      fcnt_d [NDIN];

    // dedicated, then index, a, b of channels 0..3
    assign raw = {quad_phase_b_in, quad_phase_a_in, quad_index_in,
                  digital_input_n};

    // next filter values; noise on the index pins is the usual victim
    always_comb begin
        for (int i = 0; i < NDIN; i++) begin
            flt_d[i]  = flt_q[i];
            fcnt_d[i] = '0;
            if (raw[i] != flt_q[i]) begin
                if (fcnt_q[i] == FLAST) begin
                    flt_d[i] = raw[i];
                end else begin
                    fcnt_d[i] = fcnt_q[i] + 1'b1;
                end
            end
        end
    end

    // filter registers, one sample per clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flt_q <= '0;
            for (int i = 0; i < NDIN; i++) begin
                fcnt_q[i] <= '0;
            end
        end else begin
            flt_q <= flt_d;
            for (int i = 0; i < NDIN; i++) begin
                fcnt_q[i] <= fcnt_d[i];
            end
        end
    end

    // ==================================================================
    // register file
    logic              take;                 // request accepted now
    logic              ack_q;
    logic [31:0]       dat_q, dat_d;         // read data
    logic [NCH-1:0]    dir_q, dir_d;         // pwm+direction select
    logic [NCH-1:0]    pdm_q, pdm_d;         // pulse-density select
    logic              wden_q, wden_d;       // watchdog enable
    logic              outen_q, outen_d;     // configured, drive pins
    logic [NDED-1:0]   dout_q, dout_d;       // outputs 0..9
    logic [NDOUT-1:0]  inv_q, inv_d;         // output invert flags
    logic [PWM_W-1:0]  pwmv_q [NCH];         // duty settings
    logic [PWM_W-1:0]  pwmv_d [NCH];
    logic [2*NCH-1:0]  shout_q, shout_d;     // outputs 10..17
    logic [NCH-1:0]    idx_clr;              // read of a counter
    logic [QCNT_W-1:0] qcnt [NCH];
    logic [NCH-1:0]    qidx;
    logic [31:0]       rd, wv;
    logic              trip;                 // watchdog expired

    assign take = wb_cyc_i & wb_stb_i & ~ack_q;

    // read mux and register updates, all in the accepting cycle
    always_comb begin
        rd = '0;
        unique case (wb_adr_i)
            ADR_CTRL: begin
                rd[CTRL_DIR_LSB +: NCH] = dir_q;
                rd[CTRL_PDM_LSB +: NCH] = pdm_q;
                rd[CTRL_WDEN_BIT]       = wden_q;
                rd[CTRL_OUTEN_BIT]      = outen_q;
            end
            ADR_DOUT: rd[NDED-1:0]  = dout_q;
            ADR_INV:  rd[NDOUT-1:0] = inv_q;
            ADR_DIN:  rd[NDIN-1:0]  = flt_q;
            ADR_STAT: rd[STAT_WD_BIT] = trip;
            default: begin
                for (int c = 0; c < NCH; c++) begin
                    if (wb_adr_i == ADR_QCNT0 + 8'(4*c)) begin
                        // 14 bits wrap; host differences stay exact
                        rd[QCNT_W-1:0]   = qcnt[c];
                        rd[QCNT_IDX_BIT] = qidx[c];
                    end
                    if (wb_adr_i == ADR_PWM0 + 8'(4*c)) begin
                        rd[PWM_W-1:0]  = pwmv_q[c];
                        rd[PWM_UPO_BIT] = shout_q[2*c];
                        rd[PWM_DNO_BIT] = shout_q[2*c+1];
                    end
                end
            end
        endcase
        wv      = wmerge(rd, wb_dat_i, wb_sel_i);
        dat_d   = take ? rd : dat_q;
        dir_d   = dir_q;
        pdm_d   = pdm_q;
        wden_d  = wden_q;
        outen_d = outen_q;
        dout_d  = dout_q;
        inv_d   = inv_q;
        shout_d = shout_q;
        idx_clr = '0;
        for (int c = 0; c < NCH; c++) begin
            pwmv_d[c] = pwmv_q[c];
            if (take && !wb_we_i && wb_adr_i == ADR_QCNT0 + 8'(4*c)) begin
                idx_clr[c] = 1'b1;
            end
            // shared outputs move with their duty setting
            if (take && wb_we_i && wb_adr_i == ADR_PWM0 + 8'(4*c)) begin
                pwmv_d[c]       = wv[PWM_W-1:0];
                shout_d[2*c]    = wv[PWM_UPO_BIT];
                shout_d[2*c+1]  = wv[PWM_DNO_BIT];
            end
        end
        if (take && wb_we_i) begin
            if (wb_adr_i == ADR_CTRL) begin
                dir_d   = wv[CTRL_DIR_LSB +: NCH];
                pdm_d   = wv[CTRL_PDM_LSB +: NCH];
                wden_d  = wv[CTRL_WDEN_BIT];
                outen_d = wv[CTRL_OUTEN_BIT];
            end
            if (wb_adr_i == ADR_DOUT) begin
                dout_d = wv[NDED-1:0];
            end
            if (wb_adr_i == ADR_INV) begin
                inv_d = wv[NDOUT-1:0];
            end
        end
    end

    // register file flops; watchdog on, pins off after reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            dat_q   <= '0;
            dir_q   <= CTRL_RESET[CTRL_DIR_LSB +: NCH];
            pdm_q   <= CTRL_RESET[CTRL_PDM_LSB +: NCH];
            wden_q  <= CTRL_RESET[CTRL_WDEN_BIT];
            outen_q <= CTRL_RESET[CTRL_OUTEN_BIT];
            dout_q  <= '0;
            inv_q   <= '0;
            shout_q <= '0;
            for (int c = 0; c < NCH; c++) begin
                pwmv_q[c] <= '0;
            end
        end else begin
            ack_q   <= take;
            dat_q   <= dat_d;
            dir_q   <= dir_d;
            pdm_q   <= pdm_d;
            wden_q  <= wden_d;
            outen_q <= outen_d;
            dout_q  <= dout_d;
            inv_q   <= inv_d;
            shout_q <= shout_d;
            for (int c = 0; c < NCH; c++) begin
                pwmv_q[c] <= pwmv_d[c];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ==================================================================
    // watchdog: any bus access restarts it
    logic [WDW-1:0] wd_q, wd_d;

    always_comb begin
        if (take) begin
            wd_d = '0;
        end else if (wd_q == WD_END) begin
            wd_d = wd_q;                   // saturate until next access
        end else begin
            wd_d = wd_q + 1'b1;
        end
        trip = wden_q && (wd_q == WD_END);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_q <= '0;
        end else begin
            wd_q <= wd_d;
        end
    end

    // ==================================================================
    // channels
    logic [NCH-1:0] pu, pd;                // raw pwm up/down

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        sqp_quad u_quad (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .phase_a  (flt_q[NDED_IN + NCH + c]),
            .phase_b  (flt_q[NDED_IN + 2*NCH + c]),
            .index    (flt_q[NDED_IN + c]),
            .idx_clr  (idx_clr[c]),
            .count    (qcnt[c]),
            .idx_seen (qidx[c])
        );
        sqp_pwm u_pwm (
            .sys_clk  (sys_clk),
            .rst      (rst),
            .value    (pwmv_q[c]),
            .pwmdir   (dir_q[c]),
            .pdm      (pdm_q[c]),
            .up_out   (pu[c]),
            .down_out (pd[c])
        );
    end

    // ==================================================================
    // pins: shared outputs xor onto pwm, invert, tristate when idle
    logic [NCH-1:0]  up_q, up_d, dn_q, dn_d;
    logic [NDED-1:0] do_q, do_d;
    logic            drv_q, drv_d, led_q, led_d;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            // host must leave the pwm side idle when sharing a pin
            up_d[c] = pu[c] ^ shout_q[2*c] ^ inv_q[NDED + 2*c];
            dn_d[c] = pd[c] ^ shout_q[2*c+1]
                      ^ inv_q[NDED + 2*c + 1];
        end
        do_d  = dout_q ^ inv_q[NDED-1:0];
        drv_d = outen_q & ~trip;
        led_d = pu[0] ^ pd[0];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            up_q  <= '0;
            dn_q  <= '0;
            do_q  <= '0;
            drv_q <= 1'b0;
            led_q <= 1'b0;
        end else begin
            up_q  <= up_d;
            dn_q  <= dn_d;
            do_q  <= do_d;
            drv_q <= drv_d;
            led_q <= led_d;
        end
    end

    assign pwm_up_out        = up_q;
    assign pwm_down_out      = dn_q;
    assign digital_output_n  = do_q;
    assign pwm_up_oe         = {NCH{drv_q}};
    assign pwm_down_oe       = {NCH{drv_q}};
    assign digital_output_oe = {NDED{drv_q}};
    assign led_out           = led_q;

    // ==================================================================
    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_wd_tristate: assert property (wden_q && wd_q == WD_END && !take
        |=> ##1 pwm_up_oe == '0 && digital_output_oe == '0)
        else $error("watchdog did not release pins");
    a_wd_restart: assert property (take |=> wd_q == 0)
        else $error("access did not restart watchdog");
    a_unconfig_off: assert property (!outen_q |=> pwm_down_oe == '0)
        else $error("pins driven before configuration");
    a_led_xor: assert property (led_out == $past(pu[0] ^ pd[0]))
        else $error("led does not track channel 0");
    a_filter_hold: assert property ($changed(flt_q[NDED_IN])
        |-> $past(fcnt_q[NDED_IN]) == FLAST)
        else $error("short pulse passed the filter");
    a_din_latch: assert property (take && !wb_we_i && wb_adr_i == ADR_DIN
        |=> wb_dat_o[NDIN-1:0] == $past(flt_q))
        else $error("inputs not latched together");
    a_shared_xor: assert property (pwm_up_out[0]
        == $past(pu[0] ^ shout_q[0] ^ inv_q[NDED]))
        else $error("shared output not xored");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_wd_trip: cover property (wden_q && outen_q ##1 trip);
    c_filter: cover property ($rose(flt_q[NDED_IN]));
endmodule

//--- sqp_host.sv
// host-side bus master model for the servo io block
`timescale 1ns/1ps
module sqp_host (
    input  wire logic        sys_clk,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    output logic [7:0]       wb_adr_i,
    output logic [31:0]      wb_dat_i,
    output logic             wb_we_i,
    output logic             wb_cyc_i
);
    // idle bus from time zero
    initial begin
        wb_cyc_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = '0;
        wb_dat_i = '0;
    end
    // one classic cycle held until ack is sampled high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        q = '0;
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        // no cycle budget here: only the bench watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

//--- tb.sv
// self-checking bench for the servo io block
`timescale 1ns/1ps
module tb;
    import sqp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  wb_adr_i, din = '0;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        wb_we_i, wb_cyc_i, wb_ack_o, led_out;
    logic [3:0]  qa = '0;
    logic [3:0]  qb = '0;
    logic [3:0]  qz = '0;
    logic [3:0]  up, upoe, dn, dnoe;
    logic [9:0]  dout, doe, dval;
    int          fails = 0, checked = 0, pos = 0, ph = 0, hi = 0;
    logic [1:0]  gray [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    always #12.5 sys_clk = ~sys_clk;
    sqp_host host (.sys_clk(sys_clk), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i));
    sqp_top #(.WD_LIMIT(200)) dut (.sys_clk(sys_clk), .rst(rst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_cyc_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .digital_input_n(din), .quad_phase_a_in(qa),
        .quad_phase_b_in(qb), .quad_index_in(qz), .pwm_up_out(up),
        .pwm_up_oe(upoe), .pwm_down_out(dn), .pwm_down_oe(dnoe),
        .digital_output_n(dout), .digital_output_oe(doe),
        .led_out(led_out));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, q);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(a, 1'b0, 32'h0, q);
    endtask
    // one gray step on channel 0; model counts up on old a xor new b
    task automatic step(input int dir);
        ph = (ph + dir + 4) % 4;
        pos += (qa[0] ^ gray[ph][0]) ? 1 : -1;
        {qa[0], qb[0]} <= gray[ph];
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, well beyond the roughly 5000 cycles used
    initial begin
        #300us;
        fails++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'hB2B8DC30));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({upoe, dnoe, doe}, 18'h0);
        rd(ADR_CTRL);
        chk(q, CTRL_RESET);
        dval = 10'($urandom);
        wr(ADR_CTRL, 32'h300);
        wr(ADR_DOUT, {22'h0, dval});
        chk(dout, dval);
        chk({upoe, dnoe, doe}, 18'h3FFFF);
        rd(8'h40);
        chk(q, 32'h0);
        // four steps forward, two back, then a glitch too short to pass
        for (int i = 0; i < 6; i++) step(i < 4 ? 1 : -1);
        qa[0] <= ~qa[0];
        repeat (6) @(posedge sys_clk);
        qa[0] <= ~qa[0];
        repeat (10) @(posedge sys_clk);
        rd(ADR_QCNT0);
        chk(q[13:0], pos[13:0]);
        qz[0] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(ADR_QCNT0);
        chk(q[31], 1'b1);
        qz[0] <= 1'b0;
        din <= 8'($urandom);
        repeat (10) @(posedge sys_clk);
        rd(ADR_QCNT0);
        chk(q[31], 1'b0);
        rd(ADR_DIN);
        chk(q[19:0], {qb, qa, qz, din});
        wr(ADR_CTRL, 32'h301);
        wr(ADR_PWM0, 32'hFFF);
        chk(dn[0], 1'b1);
        wr(ADR_PWM0, 32'h7FF);
        chk({up[0], dn[0]}, 2'b10);
        chk(led_out, 1'b1);
        wr(ADR_PWM0, 32'h207FF);
        chk(dn[0], 1'b1);
        wr(ADR_PWM0, 32'h7FF);
        wr(ADR_INV, 32'h800);
        chk(dn[0], 1'b1);
        // any 2047 cycles hold exactly |duty| highs, fixed or pdm
        for (int m = 0; m < 2; m++) begin
            hi = 0;
            wr(ADR_CTRL, m ? 32'h310 : 32'h300);
            dval = 10'($urandom);
            wr(ADR_PWM0, {22'h0, dval});
            repeat (PWM_PERIOD) begin
                @(posedge sys_clk);
                hi += up[0];
            end
            chk(hi, {22'h0, dval});
        end
        repeat (300) @(posedge sys_clk);
        chk(doe, 10'h0);
        rd(ADR_STAT);
        chk(q[0], 1'b1);
        report_and_stop;
    end
endmodule
